// *** src/usart_rx_pkg.sv ***
// Shared constants for the clocked slave receiver and its link master
package usart_rx_pkg;
  // Channels and word sizes
  localparam int CHANNELS = 2;
  localparam int WORD_BITS = 9;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_NINE = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // Bank layout of the register space; byte address is four times the word index
  localparam logic [2:0] BANK_CH_A = 3'h0;
  localparam logic [2:0] BANK_FLAGS_ONE = 3'h1;
  localparam logic [2:0] BANK_CH_B = 3'h4;
  localparam logic [2:0] BANK_CORE = 3'h7;
  localparam logic [4:0] IDX_RX_STATUS_CONTROL = 5'h13;
  localparam logic [4:0] IDX_RX_DATA_BUFFER = 5'h14;
  localparam logic [4:0] IDX_TX_STATUS_CONTROL = 5'h15;
  localparam logic [4:0] IDX_FLAGS_ONE = 5'h16;
  localparam logic [4:0] IDX_ENABLES_ONE = 5'h17;
  localparam logic [4:0] IDX_FLAGS_TWO = 5'h10;
  localparam logic [4:0] IDX_ENABLES_TWO = 5'h11;
  localparam logic [4:0] IDX_IRQ_STATUS = 5'h00;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h01;
  localparam logic [4:0] IDX_CORE_CONTROL = 5'h02;
  // Receive status and control fields
  localparam int PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_RECEIVE_BIT = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int FRAMING_ERROR_BIT = 2;
  localparam int OVERRUN_ERROR_BIT = 1;
  localparam int RECEIVED_NINTH_BIT = 0;
  localparam logic [7:0] RX_CTRL_WRITE_MASK = 8'hF0;
  // Transmit status and control fields
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int SYNC_MODE_BIT = 4;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  localparam logic [7:0] TX_CTRL_WRITE_MASK = 8'hF1;
  localparam logic [7:0] TX_CTRL_RESET = 8'h02;
  // Peripheral flag and enable fields
  localparam int RECEIVE_DONE_BIT = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  // Own interrupt block: bits 1:0 word done, bits 3:2 overrun
  localparam int IRQ_BITS = 4;
  localparam int IRQ_DONE_BASE = 0;
  localparam int IRQ_OVERRUN_BASE = 2;
  localparam int GLOBAL_IRQ_ENABLE_BIT = 0;
  localparam logic [15:0] IRQ_VECTOR = 16'h0020;

  // Byte address of a register word
  function automatic logic [11:0] reg_addr(input logic [2:0] bank, input logic [4:0] idx);
    reg_addr = {2'h0, bank, idx, 2'h0};
  endfunction

  // Word length chosen by the nine-bit option
  function automatic logic [3:0] word_len(input logic nine);
    word_len = nine ? LEN_NINE : LEN_EIGHT;
  endfunction
endpackage

// *** src/sync_link_if.sv ***
// Shift clock and serial data lines between the external master and the receiver
`timescale 1ns/1ps
interface sync_link_if;
  logic [1:0] shift_clock_pin;
  logic [1:0] serial_data_pin;
  // Receiver end only listens
  modport device (
    input shift_clock_pin,
    input serial_data_pin
  );
  // External master makes clock and data
  modport master (
    output shift_clock_pin,
    output serial_data_pin
  );
endinterface

// *** src/usart_sync_slave_receiver.sv ***
// Two-channel clocked slave serial receiver with an APB register slave
// Overview of operation
// [R1] Single receive enable ignored in slave mode
// [R2] Continuous reception keeps shifting during sleep
// [R3] Full word moves to buffer, sets done
// [R4] Enabled done interrupt wakes from sleep
// [R5] Global enable branches to fixed vector
// [R6] Software selects slave mode via control bits
// [R7] Nine-bit option captures a ninth bit
// [R8] Reception starts once continuous enable set
// [R9] Software reads status before data byte
// [R10] Clearing continuous enable clears overrun error
// [R11] Disabling port or enable aborts reception
// [R12] Warm reset keeps received ninth bit
// [R13] Master supplies shift clock on pin
// [R14] Data sampled on falling shift clock
// [R15] Two-deep buffer, overrun drops and blocks
// [R16] Buffer read advances ninth and error bits; here only the ninth bit advances, overrun stays set
// [R17] Both channels behave identically
`timescale 1ns/1ps
module usart_sync_slave_receiver
  import usart_rx_pkg::*;
(
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warm_reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core status and wake
  input wire logic core_sleep,
  output logic irq,
  output logic wake_up,
  output logic vector_branch,
  output logic [15:0] vector_address,
  // Serial link
  sync_link_if.device link
);
  // Pin synchronisers and edge history
  logic [1:0] ck_meta, ck_sync, ck_prev, dt_meta, dt_sync;
  logic [1:0] warm_meta;
  logic warm_sync;
  // Software-visible state
  logic [1:0][7:0] rx_ctrl;
  logic [1:0][7:0] tx_ctrl;
  logic [1:0][7:0] enables;
  logic [1:0] overrun;
  logic [IRQ_BITS-1:0] irq_status, irq_mask, irq_event;
  logic global_irq_enable;
  // Receive datapath
  logic [1:0][WORD_BITS-1:0] shift_reg;
  logic [1:0][3:0] bit_count;
  logic [WORD_BITS-1:0] fifo_word [CHANNELS][2];
  logic [1:0][1:0] fifo_count;
  logic [1:0] rd_ptr;
  // Derived strobes
  logic [1:0] rx_on, fall, done, push, ovf_set, pop, done_flag;
  logic [1:0][WORD_BITS-1:0] next_word;
  logic [1:0][7:0] status_read;
  logic access, wr, rd, hit;
  logic [31:0] rdata;

  // Two flops on each link pin before use, three on warm_reset; the third clock stage only records history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_meta <= 2'h3;
      ck_sync <= 2'h3;
      ck_prev <= 2'h3;
      dt_meta <= 2'h0;
      dt_sync <= 2'h0;
      warm_meta <= 2'h0;
      warm_sync <= 1'b0;
    end else begin
      ck_meta <= link.shift_clock_pin;
      ck_sync <= ck_meta;
      ck_prev <= ck_sync;
      dt_meta <= link.serial_data_pin;
      dt_sync <= dt_meta;
      warm_meta <= {warm_meta[0], warm_reset};
      warm_sync <= warm_meta[1];
    end
  end
  // Bus strobes: a transfer commits on the access edge with pready high
  assign access = psel && penable && pready;
  assign wr = access && pwrite && hit;
  assign rd = access && !pwrite;

  // Per-channel receive conditions, shared by both channels
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      // Single enable deliberately unused here
      rx_on[c] = rx_ctrl[c][PORT_ENABLE_BIT] && rx_ctrl[c][CONTINUOUS_RECEIVE_ENABLE_BIT]
        && tx_ctrl[c][SYNC_MODE_BIT] && !tx_ctrl[c][CLOCK_SOURCE_SELECT_BIT]; // see R1 see R8 see R17
      fall[c] = ck_prev[c] && !ck_sync[c]; // see R14
      done[c] = rx_on[c] && fall[c]
        && (bit_count[c] == word_len(rx_ctrl[c][NINE_BIT_RECEIVE_BIT]) - 4'h1); // see R7
      push[c] = done[c] && !overrun[c] && (fifo_count[c] != FIFO_DEPTH); // see R3
      ovf_set[c] = done[c] && !overrun[c] && (fifo_count[c] == FIFO_DEPTH); // see R15
      done_flag[c] = fifo_count[c] != 2'h0;
      next_word[c] = shift_reg[c];
      next_word[c][bit_count[c]] = dt_sync[c];
      status_read[c] = (rx_ctrl[c] & RX_CTRL_WRITE_MASK);
      status_read[c][OVERRUN_ERROR_BIT] = overrun[c];
      // Synchronous words never frame badly, so this bit stays clear
      status_read[c][FRAMING_ERROR_BIT] = 1'b0;
      status_read[c][RECEIVED_NINTH_BIT] = fifo_word[c][rd_ptr[c]][WORD_BITS-1]; // see R16
    end
    pop[0] = rd && (paddr == reg_addr(BANK_CH_A, IDX_RX_DATA_BUFFER)) && done_flag[0];
    pop[1] = rd && (paddr == reg_addr(BANK_CH_B, IDX_RX_DATA_BUFFER)) && done_flag[1];
    irq_event = {ovf_set, push}; // Done events low, overruns high
  end

  // Shift register and bit counter; clocked by pclk, stepping on synchronised link clock falls; core_sleep plays no part, so sleep is no obstacle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
      bit_count <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (!rx_on[c] || warm_sync) begin
          shift_reg[c] <= '0; // see R11
          bit_count[c] <= 4'h0;
        end else if (done[c]) begin
          shift_reg[c] <= '0;
          bit_count[c] <= 4'h0;
        end else if (fall[c]) begin
          shift_reg[c] <= next_word[c]; // see R2 see R14
          bit_count[c] <= bit_count[c] + 4'h1;
        end
      end
    end
  end

  // Two-word buffer; warm reset empties it but keeps the words, so the ninth bit survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_count <= '0;
      rd_ptr <= '0;
      for (int c = 0; c < CHANNELS; c++) begin
        fifo_word[c][0] <= '0;
        fifo_word[c][1] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (push[c]) begin
          fifo_word[c][rd_ptr[c] ^ fifo_count[c][0]] <= next_word[c]; // see R3 see R15
        end
        if (warm_sync) begin
          fifo_count[c] <= 2'h0; // see R12
        end else begin
          fifo_count[c] <= fifo_count[c] + {1'b0, push[c]} - {1'b0, pop[c]};
        end
        if (pop[c]) begin
          rd_ptr[c] <= ~rd_ptr[c]; // see R16
        end
      end
    end
  end

  // Overrun: held clear while continuous enable is low; set only when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (ovf_set[c]) begin
          overrun[c] <= 1'b1; // see R15
        end else if (!rx_ctrl[c][CONTINUOUS_RECEIVE_ENABLE_BIT] || warm_sync) begin
          overrun[c] <= 1'b0; // see R10
        end
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ctrl <= '0;
      tx_ctrl <= {TX_CTRL_RESET, TX_CTRL_RESET};
      enables <= {ENABLES_RESET, ENABLES_RESET};
      irq_mask <= '0;
      global_irq_enable <= 1'b0;
    end else if (warm_sync) begin
      rx_ctrl <= '0; // see R12
      tx_ctrl <= {TX_CTRL_RESET, TX_CTRL_RESET};
      enables <= {ENABLES_RESET, ENABLES_RESET};
      irq_mask <= '0;
      global_irq_enable <= 1'b0;
    end else if (wr) begin
      case (paddr)
        reg_addr(BANK_CH_A, IDX_RX_STATUS_CONTROL): rx_ctrl[0] <= pwdata[7:0] & RX_CTRL_WRITE_MASK;
        reg_addr(BANK_CH_B, IDX_RX_STATUS_CONTROL): rx_ctrl[1] <= pwdata[7:0] & RX_CTRL_WRITE_MASK;
        reg_addr(BANK_CH_A, IDX_TX_STATUS_CONTROL): tx_ctrl[0] <= (pwdata[7:0] & TX_CTRL_WRITE_MASK) | TX_CTRL_RESET;
        reg_addr(BANK_CH_B, IDX_TX_STATUS_CONTROL): tx_ctrl[1] <= (pwdata[7:0] & TX_CTRL_WRITE_MASK) | TX_CTRL_RESET;
        reg_addr(BANK_FLAGS_ONE, IDX_ENABLES_ONE): enables[0] <= pwdata[7:0];
        reg_addr(BANK_CH_B, IDX_ENABLES_TWO): enables[1] <= pwdata[7:0];
        reg_addr(BANK_CORE, IDX_IRQ_MASK): irq_mask <= pwdata[IRQ_BITS-1:0];
        reg_addr(BANK_CORE, IDX_CORE_CONTROL): global_irq_enable <= pwdata[GLOBAL_IRQ_ENABLE_BIT];
        default: begin
        end
      endcase
    end
  end

  // Sticky event bits, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < IRQ_BITS; i++) begin
        if (irq_event[i]) begin
          irq_status[i] <= 1'b1;
        end else if (wr && paddr == reg_addr(BANK_CORE, IDX_IRQ_STATUS) && pwdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  // Read mux and decode
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      reg_addr(BANK_CH_A, IDX_RX_STATUS_CONTROL): rdata[7:0] = status_read[0];
      reg_addr(BANK_CH_B, IDX_RX_STATUS_CONTROL): rdata[7:0] = status_read[1];
      reg_addr(BANK_CH_A, IDX_RX_DATA_BUFFER): rdata[7:0] = fifo_word[0][rd_ptr[0]][7:0];
      reg_addr(BANK_CH_B, IDX_RX_DATA_BUFFER): rdata[7:0] = fifo_word[1][rd_ptr[1]][7:0];
      reg_addr(BANK_CH_A, IDX_TX_STATUS_CONTROL): rdata[7:0] = tx_ctrl[0];
      reg_addr(BANK_CH_B, IDX_TX_STATUS_CONTROL): rdata[7:0] = tx_ctrl[1];
      reg_addr(BANK_FLAGS_ONE, IDX_FLAGS_ONE): rdata[7:0] = FLAGS_RESET | {7'h00, done_flag[0]};
      reg_addr(BANK_CH_B, IDX_FLAGS_TWO): rdata[7:0] = FLAGS_RESET | {7'h00, done_flag[1]};
      reg_addr(BANK_FLAGS_ONE, IDX_ENABLES_ONE): rdata[7:0] = enables[0];
      reg_addr(BANK_CH_B, IDX_ENABLES_TWO): rdata[7:0] = enables[1];
      reg_addr(BANK_CORE, IDX_IRQ_STATUS): rdata[IRQ_BITS-1:0] = irq_status;
      reg_addr(BANK_CORE, IDX_IRQ_MASK): rdata[IRQ_BITS-1:0] = irq_mask;
      reg_addr(BANK_CORE, IDX_CORE_CONTROL): rdata[GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable;
      default: hit = 1'b0;
    endcase
  end

  // APB answer: one wait-free access phase, registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rdata;
      pslverr <= !hit;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Interrupt, wake and vector outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      wake_up <= 1'b0;
      vector_branch <= 1'b0;
      vector_address <= 16'h0000;
    end else begin
      irq <= |(irq_status & irq_mask);
      wake_up <= core_sleep && |(done_flag & {enables[1][RECEIVE_DONE_BIT], enables[0][RECEIVE_DONE_BIT]}); // see R4
      vector_branch <= global_irq_enable
        && |(done_flag & {enables[1][RECEIVE_DONE_BIT], enables[0][RECEIVE_DONE_BIT]}); // see R5
      vector_address <= global_irq_enable ? IRQ_VECTOR : 16'h0000; // see R5
    end
  end
endmodule

// *** src/sync_link_master.sv ***
// External synchronous master: makes the shift clock and shifts words out
`timescale 1ns/1ps
module sync_link_master
  import usart_rx_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Word request
  input wire logic send_valid,
  input wire logic send_channel,
  input wire logic send_nine_bit,
  input wire logic [WORD_BITS-1:0] send_word,
  output logic send_ready,
  // Serial link
  sync_link_if.master link
);
  typedef enum logic [1:0] {IDLE, CLOCK_HIGH, CLOCK_LOW} state_type;

  // The receiver needs two system clocks per clock level to see each edge
  if (HALF_CYCLES < 2 || HALF_CYCLES > 255) begin : gen_bad_half
    $error("HALF_CYCLES out of range");
  end

  state_type state;
  logic [7:0] div;
  logic [3:0] bit_index, last_bit;
  logic chan;
  logic [WORD_BITS-1:0] word;

  // Divider, bit sequencing and pins; data changes only while the clock is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IDLE;
      div <= 8'h00;
      bit_index <= 4'h0;
      last_bit <= 4'h0;
      chan <= 1'b0;
      word <= '0;
      send_ready <= 1'b1;
      link.shift_clock_pin <= 2'h3;
      link.serial_data_pin <= 2'h0;
    end else begin
      case (state)
        IDLE: begin
          if (send_valid) begin
            state <= CLOCK_HIGH; // see R13
            chan <= send_channel;
            word <= send_word;
            last_bit <= word_len(send_nine_bit) - 4'h1; // see R7
            bit_index <= 4'h0;
            div <= 8'h00;
            send_ready <= 1'b0;
            link.serial_data_pin[send_channel] <= send_word[0];
          end
        end
        CLOCK_HIGH: begin
          if (div == 8'(HALF_CYCLES - 1)) begin
            div <= 8'h00;
            state <= CLOCK_LOW;
            link.shift_clock_pin[chan] <= 1'b0; // see R14
          end else begin
            div <= div + 8'h01;
          end
        end
        CLOCK_LOW: begin
          if (div == 8'(HALF_CYCLES - 1)) begin
            div <= 8'h00;
            link.shift_clock_pin[chan] <= 1'b1;
            if (bit_index == last_bit) begin
              state <= IDLE;
              send_ready <= 1'b1;
            end else begin
              state <= CLOCK_HIGH;
              bit_index <= bit_index + 4'h1;
              link.serial_data_pin[chan] <= word[bit_index + 4'h1];
            end
          end else begin
            div <= div + 8'h01;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule

// *** tb/sync_link_checker.sv ***
// Wire checker for the serial link: clock shape, data hold and word length
`timescale 1ns/1ps
module sync_link_checker #(
  parameter int HALF_CYCLES = 4
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link lines
  input wire logic [1:0] shift_clock_pin,
  input wire logic [1:0] serial_data_pin
);
  logic [7:0] low_run [2];
  logic [7:0] high_run [2];
  logic [7:0] falls [2];
  logic [1:0] prev_clk;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Run lengths and fall counts; a long high run closes a word and clears the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_clk <= 2'h3;
      for (int i = 0; i < 2; i++) begin
        low_run[i] <= 8'h00;
        high_run[i] <= 8'h00;
        falls[i] <= 8'h00;
      end
    end else begin
      prev_clk <= shift_clock_pin;
      for (int i = 0; i < 2; i++) begin
        low_run[i] <= shift_clock_pin[i] ? 8'h00 : low_run[i] + 8'h01;
        high_run[i] <= !shift_clock_pin[i] ? 8'h00 : (high_run[i] == 8'hFF ? 8'hFF : high_run[i] + 8'h01);
        if (high_run[i] == 2 * HALF_CYCLES) begin
          falls[i] <= 8'h00;
        end else if (prev_clk[i] && !shift_clock_pin[i]) begin
          falls[i] <= falls[i] + 8'h01;
        end
      end
    end
  end
  a_low_width_a: assert property ($rose(shift_clock_pin[0]) |-> low_run[0] == HALF_CYCLES)
    else $error("channel a clock low phase has wrong length");
  a_low_width_b: assert property ($rose(shift_clock_pin[1]) |-> low_run[1] == HALF_CYCLES)
    else $error("channel b clock low phase has wrong length");
  // Bench runs HALF_CYCLES at 4, so the high phase is four cycles
  a_high_width_a: assert property ($rose(shift_clock_pin[0]) |-> shift_clock_pin[0] [*4])
    else $error("channel a clock high phase too short");
  a_data_hold_a: assert property (!shift_clock_pin[0] && !$past(shift_clock_pin[0]) |-> $stable(serial_data_pin[0]))
    else $error("channel a data moved while clock low");
  a_data_hold_b: assert property (!shift_clock_pin[1] && !$past(shift_clock_pin[1]) |-> $stable(serial_data_pin[1]))
    else $error("channel b data moved while clock low");
  a_word_bits_a: assert property (high_run[0] == 2 * HALF_CYCLES && falls[0] != 8'h00 |-> (falls[0] == 8'h08 || falls[0] == 8'h09))
    else $error("channel a word has wrong bit count");
  a_word_bits_b: assert property (high_run[1] == 2 * HALF_CYCLES && falls[1] != 8'h00 |-> (falls[1] == 8'h08 || falls[1] == 8'h09))
    else $error("channel b word has wrong bit count");
  a_one_channel: assert property (shift_clock_pin != 2'h0)
    else $error("both channel clocks low together");
  // Main scenarios
  c_nine_a: cover property (high_run[0] == 2 * HALF_CYCLES && falls[0] == 8'h09);
  c_eight_a: cover property (high_run[0] == 2 * HALF_CYCLES && falls[0] == 8'h08);
  c_word_b: cover property (high_run[1] == 2 * HALF_CYCLES && falls[1] == 8'h09);
endmodule

// *** tb/testbench.sv ***
// Self-checking bench: register tests over APB with words sent on the link
`timescale 1ns/1ps
module testbench;
  import usart_rx_pkg::*;
  `define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
  logic pclk = 0, presetn = 0, warm_reset = 0, psel = 0, penable = 0, pwrite = 0, core_sleep = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic err, pready, pslverr, irq, wake_up, vector_branch, send_ready;
  logic [15:0] vector_address;
  logic send_valid = 0, send_channel = 0, send_nine_bit = 0;
  logic [8:0] send_word = 9'h000;
  int errors = 0, comparisons = 0, cycles = 0;
  sync_link_if link_if();
  usart_sync_slave_receiver usart_sync_slave_receiver_inst (.pclk(pclk), .presetn(presetn),
    .warm_reset(warm_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_sleep(core_sleep),
    .irq(irq), .wake_up(wake_up), .vector_branch(vector_branch), .vector_address(vector_address),
    .link(link_if));
  sync_link_master #(.HALF_CYCLES(4)) sync_link_master_inst (.pclk(pclk), .presetn(presetn),
    .send_valid(send_valid), .send_channel(send_channel), .send_nine_bit(send_nine_bit),
    .send_word(send_word), .send_ready(send_ready), .link(link_if));
  sync_link_checker #(.HALF_CYCLES(4)) sync_link_checker_inst (.pclk(pclk), .presetn(presetn),
    .shift_clock_pin(link_if.shift_clock_pin), .serial_data_pin(link_if.serial_data_pin));
  always #50 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the answer is taken at the edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed wait count; only the hang guard ends a stuck wait
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic chk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHECK(rd, {24'h0, e})
  endtask
  // Hand a word to the master; cut above zero disables reception mid-word
  task automatic send(input logic ch, input logic nine, input logic [8:0] w, input int cut);
    @(posedge pclk);
    send_valid <= 1'b1;
    send_channel <= ch;
    send_nine_bit <= nine;
    send_word <= w;
    @(posedge pclk);
    send_valid <= 1'b0;
    if (cut > 0) begin
      repeat (cut) @(posedge pclk);
      wr(12'h04C, 8'h80);
    end
    do @(posedge pclk); while (send_ready !== 1'b1);
    repeat (12) @(posedge pclk);
  endtask
  task automatic reset_vals();
    chk(12'h04C, 8'h00);
    chk(12'h054, 8'h02);
    chk(12'h0D8, 8'h02);
    chk(12'h0DC, 8'h00);
    chk(12'h24C, 8'h00);
    $display("test reset done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_vals();
    // Slave mode on both channels, unmapped place refused
    wr(12'h054, 8'h10);
    wr(12'h254, 8'h10);
    chk(12'h054, 8'h12);
    chk(12'h100, 8'h00);
    `CHECK(err, 1'b1)
    // Single enable alone receives nothing
    wr(12'h04C, 8'hA0);
    send(1'b0, 1'b0, 9'h055, 0);
    chk(12'h0D8, 8'h02);
    chk(12'h04C, 8'hA0);
    // Clock source select set keeps the port deaf
    wr(12'h054, 8'h90);
    wr(12'h04C, 8'h90);
    send(1'b0, 1'b0, 9'h055, 0);
    chk(12'h0D8, 8'h02);
    wr(12'h054, 8'h10);
    $display("test single done");
    // Two nine-bit words, status read before each data read
    wr(12'h04C, 8'hD0);
    send(1'b0, 1'b1, 9'h1A5, 0);
    send(1'b0, 1'b1, 9'h05A, 0);
    chk(12'h0D8, 8'h03);
    chk(12'h04C, 8'hD1);
    chk(12'h050, 8'hA5);
    chk(12'h04C, 8'hD0);
    chk(12'h050, 8'h5A);
    chk(12'h0D8, 8'h02);
    $display("test nine done");
    // Overrun: four eight-bit words into a two-deep buffer
    wr(12'h380, 8'h0F);
    wr(12'h04C, 8'h90);
    for (int i = 1; i < 5; i++) send(1'b0, 1'b0, 9'(i * 17), 0);
    chk(12'h04C, 8'h92);
    chk(12'h380, 8'h05);
    wr(12'h04C, 8'h80);
    chk(12'h04C, 8'h80);
    chk(12'h050, 8'h11);
    chk(12'h050, 8'h22);
    chk(12'h0D8, 8'h02);
    $display("test overrun done");
    // Abort mid-word, then a clean word must arrive whole
    wr(12'h04C, 8'h90);
    send(1'b0, 1'b0, 9'h0F0, 20);
    wr(12'h04C, 8'h90);
    send(1'b0, 1'b0, 9'h03C, 0);
    chk(12'h050, 8'h3C);
    chk(12'h0D8, 8'h02);
    $display("test abort done");
    // Word received while sleeping wakes the core
    wr(12'h380, 8'h0F);
    wr(12'h384, 8'h01);
    wr(12'h0DC, 8'h01);
    wr(12'h388, 8'h01);
    core_sleep <= 1'b1;
    send(1'b0, 1'b0, 9'h077, 0);
    `CHECK(wake_up, 1'b1)
    `CHECK(irq, 1'b1)
    `CHECK(vector_branch, 1'b1)
    `CHECK(vector_address, 16'h0020)
    wr(12'h384, 8'h00);
    chk(12'h380, 8'h01);
    `CHECK(irq, 1'b0)
    wr(12'h380, 8'h01);
    chk(12'h380, 8'h00);
    chk(12'h050, 8'h77);
    chk(12'h0D8, 8'h02);
    `CHECK(wake_up, 1'b0)
    `CHECK(vector_branch, 1'b0)
    core_sleep <= 1'b0;
    $display("test sleep done");
    // Second channel behaves alike
    wr(12'h24C, 8'hD0);
    send(1'b1, 1'b1, 9'h1E7, 0);
    chk(12'h24C, 8'hD1);
    chk(12'h380, 8'h02);
    chk(12'h250, 8'hE7);
    $display("test channel_b done");
    // Warm reset keeps the ninth bit, power reset clears all
    wr(12'h04C, 8'hD0);
    send(1'b0, 1'b1, 9'h1AB, 0);
    warm_reset <= 1'b1;
    repeat (3) @(posedge pclk);
    warm_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(12'h04C, 8'h01);
    chk(12'h0DC, 8'h00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_vals();
    final_report();
  end
endmodule
